// file: rtl/kline_bus_init_keepalive.sv
// k-line session manager: lazy bus init, status reports, keep-alives
// Function
// - bus init runs only when a pending host request must go out
// - protocol 3 slow init only; protocol 4 slow, protocol 5 fast init
// - no report during auto search; banner for protocols 3-5 otherwise
// - three dots only during slow init; none for fast init
// - banner followed by ok or error report
// - keep-alives sent when host idle; their replies are hidden
// - keep-alive interval defaults to 3 s, host may change it
// - host may replace keep-alive bytes outside a keep-alive send; later keep-alives use them
// - keep-alive message holds 1 to 6 bytes; checksum appended here
// - selector 3 iso9141 slow, 4 iso14230 slow, 5 iso14230 fast
`timescale 1ns/1ps
module kline_bus_init_keepalive #(
	parameter longint unsigned SLOW_INIT_CYCLES = kline_pkg::SLOW_INIT_CYC,
	parameter longint unsigned FAST_INIT_CYCLES = kline_pkg::FAST_INIT_CYC,
	parameter longint unsigned KA_DEF_CYCLES = kline_pkg::KEEP_ALIVE_CYC,
	parameter int unsigned TMR_W = 32
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// protocol selection
	input wire logic [3:0] protocol_i,
	input wire logic auto_search_i,
	// host request
	input wire logic req_valid_i,
	output logic req_ready_o,
	// keep-alive configuration
	input wire logic set_wakeup_interval_cmd_i,
	input wire logic [TMR_W-1:0] wakeup_interval_i,
	input wire logic set_wakeup_message_cmd_i,
	input wire logic [2:0] wakeup_len_i,
	input wire logic [47:0] wakeup_bytes_i,
	// physical init engine
	output logic init_start_o,
	output logic init_fast_o,
	input wire logic init_done_i,
	input wire logic init_ok_i,
	// keep-alive byte stream to the k-line transmitter
	output logic ka_valid_o,
	output logic [7:0] ka_byte_o,
	output logic ka_last_o,
	input wire logic ka_ready_i,
	output logic hide_reply_o,
	// link loss and status
	input wire logic link_lost_i,
	output logic linked_o,
	output logic report_valid_o,
	output kline_pkg::report_t report_o
);
	kline_pkg::state_t st_q, st_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [TMR_W-1:0] ka_ivl_q, ka_ivl_d;
	logic [2:0] len_q, len_d;
	logic [2:0] idx_q, idx_d;
	logic [7:0] sum_q, sum_d;
	logic fast_q, fast_d;
	logic quiet_q, quiet_d;
	logic [1:0] dots_q, dots_d;
	logic [2:0] wr_cnt_q, wr_cnt_d;
	logic [47:0] wr_buf_q, wr_buf_d;
	logic rd_pend_q, rd_pend_d;
	logic ka_valid_q, ka_valid_d;
	logic [7:0] ka_byte_q, ka_byte_d;
	logic ka_last_q, ka_last_d;
	logic init_start_q, init_start_d;
	logic rpt_v_q, rpt_v_d;
	kline_pkg::report_t rpt_q, rpt_d;
	logic kline_proto;
	logic [TMR_W-1:0] dot_step;

	ka_msg_if msg ();
	ka_msg_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.port(msg.mem)
	);

	function automatic logic is_kline(input logic [3:0] p);
		is_kline = (p == kline_pkg::PROTO_ISO9141_SLOW) ||
			(p == kline_pkg::PROTO_ISO14230_SLOW) ||
			(p == kline_pkg::PROTO_ISO14230_FAST);
	endfunction : is_kline

	assign kline_proto = is_kline(protocol_i);
	// slow init split into NUM_DOTS+1 equal parts, a dot at the end of each but the last
	assign dot_step = TMR_W'(SLOW_INIT_CYCLES / (kline_pkg::NUM_DOTS + 1));

	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		ka_ivl_d = ka_ivl_q;
		len_d = len_q;
		idx_d = idx_q;
		sum_d = sum_q;
		fast_d = fast_q;
		quiet_d = quiet_q;
		dots_d = dots_q;
		wr_cnt_d = wr_cnt_q;
		wr_buf_d = wr_buf_q;
		rd_pend_d = 1'b0;
		ka_valid_d = ka_valid_q;
		ka_byte_d = ka_byte_q;
		ka_last_d = ka_last_q;
		init_start_d = 1'b0;
		rpt_v_d = 1'b0;
		rpt_d = kline_pkg::RPT_NONE;
		msg.wr_en = 1'b0;
		msg.wr_addr = 3'h0;
		msg.wr_data = 8'h00;
		msg.rd_addr = idx_q;
		req_ready_o = 1'b0;
		if (set_wakeup_interval_cmd_i && wakeup_interval_i != '0) begin
			ka_ivl_d = wakeup_interval_i;
		end
		// bytes land one per cycle; a keep-alive in flight keeps old copy unless the command lands on its launch cycle
		if (set_wakeup_message_cmd_i && st_q != kline_pkg::ST_KA_SEND &&
				wakeup_len_i >= 3'(kline_pkg::MSG_MIN) &&
				wakeup_len_i <= 3'(kline_pkg::MSG_MAX)) begin
			wr_cnt_d = wakeup_len_i;
			wr_buf_d = wakeup_bytes_i;
			len_d = wakeup_len_i;
		end else if (wr_cnt_q != 3'h0) begin
			msg.wr_en = 1'b1;
			msg.wr_addr = len_q - wr_cnt_q;
			msg.wr_data = wr_buf_q[47:40];
			wr_buf_d = {wr_buf_q[39:0], 8'h00};
			wr_cnt_d = wr_cnt_q - 3'h1;
		end
		unique case (st_q)
			kline_pkg::ST_IDLE: begin
				if (req_valid_i && kline_proto) begin
					st_d = kline_pkg::ST_INIT;
					fast_d = (protocol_i == kline_pkg::PROTO_ISO14230_FAST);
					quiet_d = auto_search_i;
					init_start_d = 1'b1;
					tmr_d = '0;
					dots_d = 2'h0;
					if (!auto_search_i) begin
						rpt_v_d = 1'b1;
						rpt_d = kline_pkg::RPT_BANNER;
					end
				end else if (req_valid_i) begin
					req_ready_o = 1'b1;
				end
			end
			kline_pkg::ST_INIT: begin
				tmr_d = tmr_q + 1'b1;
				if (!fast_q && !quiet_q && dots_q != 2'(kline_pkg::NUM_DOTS) &&
						tmr_q == dot_step * TMR_W'({dots_q + 2'h1})) begin
					dots_d = dots_q + 2'h1;
					rpt_v_d = 1'b1;
					rpt_d = kline_pkg::RPT_DOT;
				end
				if (init_done_i) begin
					rpt_v_d = !quiet_q;
					rpt_d = init_ok_i ? kline_pkg::RPT_OK :
						kline_pkg::RPT_ERROR;
					st_d = init_ok_i ? kline_pkg::ST_HOST_SEND :
						kline_pkg::ST_IDLE;
					tmr_d = '0;
				end
			end
			kline_pkg::ST_HOST_SEND: begin
				req_ready_o = 1'b1;
				tmr_d = '0;
				if (!req_valid_i) begin
					st_d = kline_pkg::ST_LINK;
				end
			end
			kline_pkg::ST_LINK: begin
				tmr_d = tmr_q + 1'b1;
				if (req_valid_i) begin
					req_ready_o = 1'b1;
					tmr_d = '0;
				end else if (tmr_q >= ka_ivl_q - 1'b1 && wr_cnt_q == 3'h0) begin
					st_d = kline_pkg::ST_KA_SEND;
					// idx_q still points at the last byte of the previous keep-alive here
					msg.rd_addr = 3'h0;
					idx_d = 3'h0;
					sum_d = 8'h00;
					rd_pend_d = 1'b1;
				end
			end
			kline_pkg::ST_KA_SEND: begin
				if (rd_pend_q) begin
					ka_valid_d = 1'b1;
					ka_byte_d = msg.rd_data;
					ka_last_d = 1'b0;
					sum_d = sum_q + msg.rd_data;
				end else if (ka_valid_q && ka_ready_i) begin
					if (ka_last_q) begin
						ka_valid_d = 1'b0;
						ka_last_d = 1'b0;
						st_d = kline_pkg::ST_LINK;
						tmr_d = '0;
					end else if (idx_q == len_q - 3'h1) begin
						ka_byte_d = sum_q;
						ka_last_d = 1'b1;
					end else begin
						ka_valid_d = 1'b0;
						idx_d = idx_q + 3'h1;
						msg.rd_addr = idx_q + 3'h1;
						rd_pend_d = 1'b1;
					end
				end
			end
			default: st_d = kline_pkg::ST_IDLE;
		endcase
		if (link_lost_i && st_q != kline_pkg::ST_INIT) begin
			st_d = kline_pkg::ST_IDLE;
			// no init pulse or banner for a start that loss cancels
			init_start_d = 1'b0;
			rpt_v_d = 1'b0;
			rpt_d = kline_pkg::RPT_NONE;
			ka_valid_d = 1'b0;
			ka_last_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= kline_pkg::ST_IDLE;
			tmr_q <= '0;
			ka_ivl_q <= TMR_W'(KA_DEF_CYCLES);
			len_q <= kline_pkg::DEF_MSG_LEN;
			idx_q <= 3'h0;
			sum_q <= 8'h00;
			fast_q <= 1'b0;
			quiet_q <= 1'b0;
			dots_q <= 2'h0;
			wr_cnt_q <= 3'h0;
			wr_buf_q <= '0;
			rd_pend_q <= 1'b0;
			ka_valid_q <= 1'b0;
			ka_byte_q <= 8'h00;
			ka_last_q <= 1'b0;
			init_start_q <= 1'b0;
			rpt_v_q <= 1'b0;
			rpt_q <= kline_pkg::RPT_NONE;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			ka_ivl_q <= ka_ivl_d;
			len_q <= len_d;
			idx_q <= idx_d;
			sum_q <= sum_d;
			fast_q <= fast_d;
			quiet_q <= quiet_d;
			dots_q <= dots_d;
			wr_cnt_q <= wr_cnt_d;
			wr_buf_q <= wr_buf_d;
			rd_pend_q <= rd_pend_d;
			ka_valid_q <= ka_valid_d;
			ka_byte_q <= ka_byte_d;
			ka_last_q <= ka_last_d;
			init_start_q <= init_start_d;
			rpt_v_q <= rpt_v_d;
			rpt_q <= rpt_d;
		end
	end

	assign init_start_o = init_start_q;
	assign init_fast_o = fast_q;
	assign ka_valid_o = ka_valid_q;
	assign ka_byte_o = ka_byte_q;
	assign ka_last_o = ka_last_q;
	// replies to keep-alives are dropped by the receive path
	assign hide_reply_o = (st_q == kline_pkg::ST_KA_SEND);
	assign linked_o = (st_q == kline_pkg::ST_LINK) ||
		(st_q == kline_pkg::ST_KA_SEND) || (st_q == kline_pkg::ST_HOST_SEND);
	assign report_valid_o = rpt_v_q;
	assign report_o = rpt_q;
endmodule : kline_bus_init_keepalive

// file: rtl/kline_pkg.sv
// constants and types for the k-line session manager
package kline_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SLOW_INIT_MIN_S = 2;
	localparam int unsigned SLOW_INIT_MAX_S = 3;
	localparam int unsigned KEEP_ALIVE_DEF_S = 3;
	localparam longint unsigned SLOW_INIT_CYC = longint'(SLOW_INIT_MIN_S) * CLK_HZ;
	localparam longint unsigned KEEP_ALIVE_CYC = longint'(KEEP_ALIVE_DEF_S) * CLK_HZ;
	localparam int unsigned FAST_INIT_MS = 50;
	localparam longint unsigned FAST_INIT_CYC = longint'(FAST_INIT_MS) * (CLK_HZ / 1000);
	localparam int unsigned MSG_MAX = 6;
	localparam int unsigned MSG_MIN = 1;
	localparam logic [3:0] PROTO_ISO9141_SLOW = 4'h3;
	localparam logic [3:0] PROTO_ISO14230_SLOW = 4'h4;
	localparam logic [3:0] PROTO_ISO14230_FAST = 4'h5;
	localparam logic [7:0] DEF_MSG_B0 = 8'h68;
	localparam logic [7:0] DEF_MSG_B1 = 8'h6A;
	localparam logic [7:0] DEF_MSG_B2 = 8'hF1;
	localparam logic [7:0] DEF_MSG_B3 = 8'h01;
	localparam logic [7:0] DEF_MSG_B4 = 8'h00;
	localparam logic [2:0] DEF_MSG_LEN = 3'h5;
	localparam logic [2:0] NUM_DOTS = 3'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INIT = 3'b001,
		ST_LINK = 3'b010,
		ST_KA_SEND = 3'b011,
		ST_HOST_SEND = 3'b100
	} state_t;
	typedef enum logic [2:0] {
		RPT_NONE = 3'h0,
		RPT_BANNER = 3'h1,
		RPT_DOT = 3'h2,
		RPT_OK = 3'h3,
		RPT_ERROR = 3'h4
	} report_t;
endpackage : kline_pkg

// file: rtl/ka_msg_if.sv
// keep-alive message store access between manager and memory
`timescale 1ns/1ps
interface ka_msg_if;
	logic wr_en;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;
	logic [2:0] rd_addr;
	logic [7:0] rd_data;
	modport mgr (output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data);
endinterface : ka_msg_if

// file: rtl/ka_msg_mem.sv
// keep-alive message byte store, registered read
`timescale 1ns/1ps
module ka_msg_mem (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// access
	ka_msg_if.mem port
);
	logic [7:0] mem_q [kline_pkg::MSG_MAX];
	logic [7:0] mem_d [kline_pkg::MSG_MAX];
	logic [7:0] rd_q;
	logic [7:0] rd_d;
	always_comb begin
		mem_d = mem_q;
		if (port.wr_en && port.wr_addr < 3'(kline_pkg::MSG_MAX)) begin
			mem_d[port.wr_addr] = port.wr_data;
		end
		rd_d = 8'h00;
		if (port.rd_addr < 3'(kline_pkg::MSG_MAX)) begin
			rd_d = mem_q[port.rd_addr];
		end
	end
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_q[0] <= kline_pkg::DEF_MSG_B0;
			mem_q[1] <= kline_pkg::DEF_MSG_B1;
			mem_q[2] <= kline_pkg::DEF_MSG_B2;
			mem_q[3] <= kline_pkg::DEF_MSG_B3;
			mem_q[4] <= kline_pkg::DEF_MSG_B4;
			mem_q[5] <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			mem_q <= mem_d;
			rd_q <= rd_d;
		end
	end
	assign port.rd_data = rd_q;
endmodule : ka_msg_mem

// file: tb/kline_bus_init_keepalive_assertions.sv
// port assertions for the k-line session manager
`timescale 1ns/1ps
module kline_bus_init_keepalive_assertions #(
	parameter longint unsigned KA_DEF_CYCLES = 200
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// watched ports
	input wire logic [3:0] protocol_i,
	input wire logic auto_search_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic init_start_o,
	input wire logic init_fast_o,
	input wire logic init_done_i,
	input wire logic init_ok_i,
	input wire logic ka_valid_o,
	input wire logic [7:0] ka_byte_o,
	input wire logic ka_ready_i,
	input wire logic hide_reply_o,
	input wire logic report_valid_o,
	input wire kline_pkg::report_t report_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence banner_s;
		report_valid_o && report_o == kline_pkg::RPT_BANNER;
	endsequence
	sequence started_s;
		##[0:1] init_start_o;
	endsequence
	lazy_init_a: assert property (init_start_o |-> $past(req_valid_i))
		else $error("init started with no request pending");
	fast_sel_a: assert property (
		init_start_o && protocol_i == 4'h5 |=> init_fast_o)
		else $error("protocol 5 did not pick fast init");
	slow_sel_a: assert property (
		init_start_o && protocol_i inside {4'h3, 4'h4} |=> !init_fast_o)
		else $error("protocol 3 or 4 did not pick slow init");
	quiet_search_a: assert property (auto_search_i |-> !report_valid_o)
		else $error("report during auto search");
	banner_start_a: assert property (banner_s |-> started_s)
		else $error("banner without init start");
	dot_slow_a: assert property (
		report_valid_o && report_o == kline_pkg::RPT_DOT |-> !init_fast_o)
		else $error("dot during fast init");
	init_result_a: assert property (init_done_i && !auto_search_i |=>
		report_valid_o && report_o == ($past(init_ok_i) ?
		kline_pkg::RPT_OK : kline_pkg::RPT_ERROR))
		else $error("wrong or missing init result report");
	ka_hidden_a: assert property (ka_valid_o |-> hide_reply_o)
		else $error("keep-alive byte while replies shown");
	ka_hold_a: assert property (ka_valid_o && !ka_ready_i |=>
		ka_valid_o && $stable(ka_byte_o))
		else $error("keep-alive byte dropped before taken");
	req_quiet_a: assert property (
		req_valid_i && req_ready_o |=> !ka_valid_o [*8])
		else $error("keep-alive right after a request");
endmodule : kline_bus_init_keepalive_assertions
bind kline_bus_init_keepalive kline_bus_init_keepalive_assertions #(
	.KA_DEF_CYCLES(KA_DEF_CYCLES)
) i_kline_bus_init_keepalive_assertions (.clk_sys_i, .sys_rst_i,
	.protocol_i, .auto_search_i, .req_valid_i, .req_ready_o, .init_start_o,
	.init_fast_o, .init_done_i, .init_ok_i, .ka_valid_o, .ka_byte_o,
	.ka_ready_i, .hide_reply_o, .report_valid_o, .report_o);

// file: tb/kline_far_model.sv
// init engine and k-line transmitter stand-in
`timescale 1ns/1ps
module kline_far_model #(
	parameter int SLOW_CYC = 350,
	parameter int FAST_CYC = 20
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// init engine
	input wire logic init_start_i,
	input wire logic init_fast_i,
	output logic init_done_o,
	output logic init_ok_o,
	// transmitter and control
	output logic ka_ready_o,
	input wire logic ok_cfg_i,
	input wire logic stall_i
);
	int cnt_q;
	logic run_q;
	logic tog_q;
	logic fin;
	// slow length past the third dot at 300 so all three dots show
	assign fin = run_q && cnt_q == (init_fast_i ? FAST_CYC : SLOW_CYC);
	// ready only every other cycle when stalling
	assign ka_ready_o = !stall_i || tog_q;
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			{cnt_q, run_q, tog_q, init_done_o, init_ok_o} <= '0;
		end else begin
			run_q <= init_start_i || (run_q && !fin);
			cnt_q <= init_start_i ? 1 : cnt_q + 1;
			tog_q <= !tog_q;
			init_done_o <= fin;
			// result is meaningless off the done pulse, so it wanders
			init_ok_o <= fin ? ok_cfg_i : !init_ok_o;
		end
	end
endmodule : kline_far_model

// file: tb/kline_bus_init_keepalive_tb.sv
// self-checking bench for the k-line session manager
`timescale 1ns/1ps
module kline_bus_init_keepalive_tb;
	logic clk_sys_i = 0, sys_rst_i = 1, auto_search_i = 0, req_valid_i = 0;
	logic set_wakeup_interval_cmd_i = 0, set_wakeup_message_cmd_i = 0;
	logic link_lost_i = 0, ok_cfg = 1, stall_cfg = 0;
	logic [3:0] protocol_i = 4'h3;
	logic [31:0] wakeup_interval_i = 32'h00000000;
	logic [2:0] wakeup_len_i = 3'h0;
	logic [47:0] wakeup_bytes_i = 48'h000000000000;
	logic req_ready_o, init_start_o, init_fast_o, init_done_i, init_ok_i;
	logic ka_valid_o, ka_last_o, ka_ready_i, report_valid_o, linked_o;
	logic [7:0] ka_byte_o;
	kline_pkg::report_t report_o;
	int fails = 0, tests_run = 0, n_start, n_ban, n_dot, n_ok, n_err;
	logic [8:0] kq[$];
	kline_bus_init_keepalive #(.SLOW_INIT_CYCLES(400), .KA_DEF_CYCLES(200))
		i_kline_bus_init_keepalive (.clk_sys_i, .sys_rst_i, .protocol_i,
		.auto_search_i, .req_valid_i, .req_ready_o, .set_wakeup_interval_cmd_i,
		.wakeup_interval_i, .set_wakeup_message_cmd_i, .wakeup_len_i,
		.wakeup_bytes_i, .init_start_o, .init_fast_o, .init_done_i, .init_ok_i,
		.ka_valid_o, .ka_byte_o, .ka_last_o, .ka_ready_i, .hide_reply_o(),
		.link_lost_i, .linked_o, .report_valid_o, .report_o);
	kline_far_model i_kline_far_model (.clk_sys_i, .sys_rst_i,
		.init_start_i(init_start_o), .init_fast_i(init_fast_o),
		.init_done_o(init_done_i), .init_ok_o(init_ok_i),
		.ka_ready_o(ka_ready_i), .ok_cfg_i(ok_cfg), .stall_i(stall_cfg));
	always #5 clk_sys_i = ~clk_sys_i;
	// counted mid-cycle, away from the edge that launches the outputs
	always @(negedge clk_sys_i) begin
		n_start += int'(init_start_o === 1'b1);
		n_ban += int'(report_valid_o && report_o == kline_pkg::RPT_BANNER);
		n_dot += int'(report_valid_o && report_o == kline_pkg::RPT_DOT);
		n_ok += int'(report_valid_o && report_o == kline_pkg::RPT_OK);
		n_err += int'(report_valid_o && report_o == kline_pkg::RPT_ERROR);
		if (ka_valid_o && ka_ready_i) begin
			kq.push_back({ka_last_o, ka_byte_o});
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic go_idle(input logic [3:0] p, input logic a);
		link_lost_i <= 1'b1;
		protocol_i <= p;
		auto_search_i <= a;
		@(posedge clk_sys_i);
		link_lost_i <= 1'b0;
		@(posedge clk_sys_i);
		{n_start, n_ban, n_dot, n_ok, n_err} = '0;
	endtask : go_idle
	// host stand-in; serial setup, clear confirm, code decoding stay host-side
	// ready is looked at mid-cycle, then taken on the next rising edge
	task automatic send_req();
		int n;
		n = 0;
		@(posedge clk_sys_i);
		req_valid_i <= 1'b1;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 3000);
		@(posedge clk_sys_i);
		req_valid_i <= 1'b0;
		chk(16'(n < 3000), 16'h0001);
	endtask : send_req
	function automatic logic [15:0] cnt4();
		return {4'(n_start), 4'(n_ban), 4'(n_dot), 4'(n_ok)};
	endfunction : cnt4
	task automatic ka_wait(input int lo, input int hi);
		int n;
		n = 0;
		kq.delete();
		while (kq.size() == 0 && n < 1000) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk(16'(n >= lo && n <= hi), 16'h0001);
		while (!(kq.size() > 0 && kq[$][8] === 1'b1) && n < 1100) begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask : ka_wait
	task automatic ka_check(input logic [7:0] e[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (e[i]) s += e[i];
		e.push_back(s);
		chk(16'(kq.size()), 16'(e.size()));
		foreach (e[i]) chk(kq[i], {i == e.size() - 1, e[i]});
	endtask : ka_check
	task automatic t_slow();
		go_idle(4'h3, 1'b0);
		repeat (100) @(posedge clk_sys_i);
		chk(16'(n_start), 16'h0000);
		send_req();
		chk(cnt4(), 16'h1131);
		chk(16'(linked_o), 16'h0001);
		$display("done slow init");
	endtask : t_slow
	task automatic t_fast();
		go_idle(4'h6, 1'b0);
		chk(16'(linked_o), 16'h0000);
		send_req();
		chk(16'(n_start), 16'h0000);
		go_idle(4'h5, 1'b0);
		send_req();
		chk(cnt4(), 16'h1101);
		$display("done fast init");
	endtask : t_fast
	task automatic t_err_auto();
		int n;
		go_idle(4'h4, 1'b0);
		ok_cfg <= 1'b0;
		req_valid_i <= 1'b1;
		for (n = 0; n < 2000 && n_err == 0; n++) @(posedge clk_sys_i);
		ok_cfg <= 1'b1;
		send_req();
		chk(cnt4(), 16'h2261);
		chk(16'(n_err), 16'h0001);
		go_idle(4'h4, 1'b1);
		send_req();
		chk(cnt4(), 16'h1000);
		$display("done error and auto search");
	endtask : t_err_auto
	task automatic t_ka();
		send_req();
		ka_wait(195, 210);
		ka_check('{8'h68, 8'h6A, 8'hF1, 8'h01, 8'h00});
		stall_cfg <= 1'b1;
		set_wakeup_interval_cmd_i <= 1'b1;
		wakeup_interval_i <= 32'h0000003C;
		set_wakeup_message_cmd_i <= 1'b1;
		wakeup_len_i <= 3'h3;
		wakeup_bytes_i <= 48'h112233000000;
		@(posedge clk_sys_i);
		set_wakeup_interval_cmd_i <= 1'b0;
		wakeup_len_i <= 3'h7;
		@(posedge clk_sys_i);
		set_wakeup_message_cmd_i <= 1'b0;
		ka_wait(50, 70);
		ka_check('{8'h11, 8'h22, 8'h33});
		$display("done keep-alive");
	endtask : t_ka
	initial begin
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_slow();
		t_fast();
		t_err_auto();
		t_ka();
		stop_test();
	end
	// whole run is a few thousand cycles; this is ample margin
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		fails++;
		stop_test();
	end
endmodule : kline_bus_init_keepalive_tb
